// ---- data_memory_defines.svh ----
// offsets, field positions, reset values and codes of the data memory mapper
`ifndef DATA_MEMORY_DEFINES_SVH
`define DATA_MEMORY_DEFINES_SVH

// data space map
`define SFR_BASE        12'hf80
`define BANK_PTR_ADDR   12'hfe0
`define PTR_LO_ADDR     12'hfe9
`define PTR_HI_ADDR     12'hfea
`define INDIRECT_ADDR   12'hfef
`define ACCESS_SPLIT    8'h80
`define EXT_SPLIT       8'h60
`define LOW_BANK        4'h0
`define HIGH_BANK       4'hf

// software register map (byte addresses)
`define CFG_REG_OFF     12'h000
`define STAT_REG_OFF    12'h004
`define BANK_REG_OFF    12'hfe0

// field positions
`define CFG_EXT_BIT     0
`define STAT_UNIMP_BIT  16
`define STAT_WRITE_BIT  17

// reset values
`define BANK_RST        4'h0
`define PTR_RST         12'h000
`define CFG_RST         1'b0

// generic special-function storage present at f80h-f8fh and ff0h-fffh
`define SFR_IMPL_DEFAULT 128'hffff_0000_0000_0000_0000_0000_0000_ffff

// bus answers
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

// ---- data_memory_pkg.sv ----
// types shared by the data memory mapper modules
package data_memory_pkg;
  typedef logic [11:0] addr_t;
  typedef logic [7:0]  byte_t;
  typedef logic [3:0]  bank_t;
  typedef logic [31:0] word_t;
  typedef logic [1:0]  resp_t;
endpackage : data_memory_pkg

// ---- map_if.sv ----
// address-mapping signals between the top and the mapper
`timescale 1ns/1ps
interface map_if;
  import data_memory_pkg::*;
  logic  bank_sel;
  logic  full_move;
  logic  ext_en;
  byte_t offset;
  bank_t bank;
  addr_t ptr;
  addr_t src_in;
  addr_t dst_in;
  addr_t addr;
  addr_t dst;
  modport mapper (input bank_sel, full_move, ext_en, offset, bank, ptr, src_in, dst_in,
                  output addr, dst);
  modport user (output bank_sel, full_move, ext_en, offset, bank, ptr, src_in, dst_in,
                input addr, dst);
endinterface : map_if

// ---- address_mapper.sv ----
// combinational data address former: bank, fast window, indexed window, full address
`timescale 1ns/1ps
`include "data_memory_defines.svh"
module address_mapper (
  // mapping bus
  map_if.mapper m
);
  import data_memory_pkg::*;

  wire   low_half = m.offset < `ACCESS_SPLIT;
  wire   ext_hit  = m.ext_en && (m.offset < `EXT_SPLIT);
  wire   addr_t banked   = {m.bank, m.offset};                              // see [RULE_02] see [RULE_12]
  wire   addr_t window   = low_half ? {`LOW_BANK, m.offset}
                                    : {`HIGH_BANK, m.offset};               // see [RULE_01] see [RULE_15]
  // indexed window: low offsets become displacements from the pointer
  wire   addr_t indexed  = m.ptr + {4'h0, m.offset};                        // see [RULE_05]
  wire   addr_t fast     = ext_hit ? indexed : window;                      // see [RULE_03]
  wire   addr_t short_a  = m.bank_sel ? banked : fast;

  assign m.addr = m.full_move ? m.src_in : short_a;                         // see [RULE_10]
  assign m.dst  = m.full_move ? m.dst_in : short_a;
endmodule : address_mapper

// ---- data_memory_bank_mapper.sv ----
// data memory bank mapper with general ram, special-function storage and axi4-lite access
// What this block does
// [RULE_01] fast window: bank 0 low, bank 15 high
// [RULE_02] select bit one: bank pointer plus offset
// [RULE_03] select bit zero: fast window, bank pointer ignored
// [RULE_04] fast window access completes in one cycle
// [RULE_05] extended set enables modified fast window
// [RULE_06] general ram starts at 000h, grows upward
// [RULE_07] general ram never cleared by reset
// [RULE_08] special area f80h-fffh, static storage
// [RULE_09] unimplemented special addresses read zero
// [RULE_10] full move uses complete 12-bit addresses
// [RULE_11] indirect port redirects through its pointer
// [RULE_12] sixteen banks of 256 bytes
// [RULE_13] bank pointer upper four bits read zero
// [RULE_14] unimplemented banks: writes dropped, reads zero
// [RULE_15] window offsets map to 000h or f00h
`timescale 1ns/1ps
`include "data_memory_defines.svh"
module data_memory_bank_mapper #(
  parameter int     RAM_BYTES = 1024,
  parameter [127:0] SFR_IMPL  = `SFR_IMPL_DEFAULT
) (
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // axi4-lite write
  input  wire data_memory_pkg::addr_t awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire data_memory_pkg::word_t wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output data_memory_pkg::resp_t     bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  // axi4-lite read
  input  wire data_memory_pkg::addr_t araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output data_memory_pkg::word_t     rdata,
  output data_memory_pkg::resp_t     rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  // cpu access port
  input  wire logic                  cpu_req,
  input  wire logic                  cpu_we,
  input  wire logic                  cpu_bank_sel,
  input  wire logic                  cpu_full_move,
  input  wire data_memory_pkg::byte_t cpu_offset,
  input  wire data_memory_pkg::addr_t cpu_src_addr,
  input  wire data_memory_pkg::addr_t cpu_dst_addr,
  input  wire data_memory_pkg::byte_t cpu_wdata,
  output data_memory_pkg::byte_t     cpu_rdata,
  output logic                       cpu_ack,
  output data_memory_pkg::addr_t     cpu_addr
);
  import data_memory_pkg::*;

  localparam int    RAM_AW    = $clog2(RAM_BYTES);
  localparam addr_t RAM_LIMIT = addr_t'(RAM_BYTES);

  // storage; ram carries no reset so its contents survive every reset
  byte_t ram_mem [RAM_BYTES];                                   // see [RULE_06] see [RULE_07]
  byte_t sfr_mem [128];                                         // see [RULE_08]

  bank_t bank_q;
  addr_t ptr_q;
  logic  ext_q;
  byte_t cpu_rdata_q;
  logic  cpu_ack_q;
  addr_t cpu_addr_q;
  addr_t last_addr_q;
  logic  last_unimp_q;
  logic  last_write_q;
  logic  awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic  aw_got_q, w_got_q;
  addr_t aw_addr_q;
  word_t w_data_q;
  logic  w_lane0_q;
  resp_t bresp_q, rresp_q;
  word_t rdata_q;

  // decoding shared by the cpu read, full move source and status paths
  function automatic logic is_mapped(input addr_t a);
    if (a < RAM_LIMIT) begin
      is_mapped = 1'b1;
    end else if (a >= `SFR_BASE) begin
      is_mapped = (a == `BANK_PTR_ADDR) || (a == `PTR_LO_ADDR) || (a == `PTR_HI_ADDR) ||
                  SFR_IMPL[a[6:0]];
    end else begin
      is_mapped = 1'b0;                                         // see [RULE_14]
    end
  endfunction : is_mapped

  function automatic byte_t read_byte(input addr_t a);
    if (a < RAM_LIMIT) begin
      read_byte = ram_mem[a[RAM_AW-1:0]];
    end else if (a == `BANK_PTR_ADDR) begin
      read_byte = {4'h0, bank_q};                               // see [RULE_13]
    end else if (a == `PTR_LO_ADDR) begin
      read_byte = ptr_q[7:0];
    end else if (a == `PTR_HI_ADDR) begin
      read_byte = {4'h0, ptr_q[11:8]};
    end else if (a >= `SFR_BASE && SFR_IMPL[a[6:0]]) begin
      read_byte = sfr_mem[a[6:0]];
    end else begin
      read_byte = 8'h00;                                        // see [RULE_09] see [RULE_14]
    end
  endfunction : read_byte

  // the indirect port has no storage; a pointer aimed at the port itself reads zero
  function automatic addr_t resolve(input addr_t a);
    resolve = (a == `INDIRECT_ADDR) ? ptr_q : a;                // see [RULE_11]
  endfunction : resolve

  map_if map_bus ();

  assign map_bus.bank_sel  = cpu_bank_sel;
  assign map_bus.full_move = cpu_full_move;
  assign map_bus.ext_en    = ext_q;
  assign map_bus.offset    = cpu_offset;
  assign map_bus.bank      = bank_q;
  assign map_bus.ptr       = ptr_q;
  assign map_bus.src_in    = cpu_src_addr;
  assign map_bus.dst_in    = cpu_dst_addr;

  address_mapper u_mapper (
    .m (map_bus)
  );

  // cpu side decode
  // kept in a process: the functions read the pointer and the storage, and a
  // continuous assignment would only wake up when the address itself changes
  addr_t eff_src;
  addr_t eff_dst;
  byte_t src_byte;
  always_comb begin
    eff_src  = resolve(map_bus.addr);
    eff_dst  = resolve(map_bus.dst);
    src_byte = read_byte(eff_src);
  end
  wire          cpu_write = cpu_req && (cpu_we || cpu_full_move);
  wire   byte_t wr_byte   = cpu_full_move ? src_byte : cpu_wdata;   // see [RULE_10]
  wire          wr_ram    = cpu_write && (eff_dst < RAM_LIMIT);
  wire          wr_bank   = cpu_write && (eff_dst == `BANK_PTR_ADDR);
  wire          wr_ptr_lo = cpu_write && (eff_dst == `PTR_LO_ADDR);
  wire          wr_ptr_hi = cpu_write && (eff_dst == `PTR_HI_ADDR);
  wire          wr_sfr    = cpu_write && (eff_dst >= `SFR_BASE) && SFR_IMPL[eff_dst[6:0]] &&
                            !wr_bank && !wr_ptr_lo && !wr_ptr_hi;
  wire          unimp     = !is_mapped(cpu_write ? eff_dst : eff_src);

  // axi side decode
  wire          aw_take   = awvalid && awready_q;
  wire          w_take    = wvalid && wready_q;
  wire          ar_take   = arvalid && arready_q;
  wire          do_write  = aw_got_q && w_got_q && !bvalid_q;
  wire          axi_cfg   = aw_addr_q == `CFG_REG_OFF;
  wire          axi_bank  = aw_addr_q == `BANK_REG_OFF;
  wire          axi_stat  = aw_addr_q == `STAT_REG_OFF;
  wire          axi_hit   = axi_cfg || axi_bank || axi_stat;
  wire          ar_cfg    = araddr == `CFG_REG_OFF;
  wire          ar_stat   = araddr == `STAT_REG_OFF;
  wire          ar_bank   = araddr == `BANK_REG_OFF;
  wire   word_t stat_word = {14'h0, last_write_q, last_unimp_q, 4'h0, last_addr_q};
  wire   word_t ar_word   = ar_cfg  ? {31'h0, ext_q} :
                            ar_stat ? stat_word :
                            ar_bank ? {28'h0, bank_q} : 32'h0000_0000;

  // a cpu bank write in the same cycle as a bus write takes precedence
  wire   bank_t bank_d    = wr_bank ? wr_byte[3:0] :                // see [RULE_13]
                            (do_write && axi_bank && w_lane0_q) ? w_data_q[3:0] : bank_q;

  // ram and special-function storage: no reset
  always_ff @(posedge aclk) begin
    if (wr_ram) begin
      ram_mem[eff_dst[RAM_AW-1:0]] <= wr_byte;                  // see [RULE_06] see [RULE_07]
    end
    if (wr_sfr) begin
      sfr_mem[eff_dst[6:0]] <= wr_byte;                         // see [RULE_08]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bank_q <= `BANK_RST;
      ptr_q  <= `PTR_RST;
    end else begin
      bank_q <= bank_d;
      if (wr_ptr_lo) begin
        ptr_q[7:0] <= wr_byte;
      end
      if (wr_ptr_hi) begin
        ptr_q[11:8] <= wr_byte[3:0];
      end
    end
  end

  // cpu answer in the cycle after the request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_ack_q    <= 1'b0;
      cpu_rdata_q  <= 8'h00;
      cpu_addr_q   <= 12'h000;
      last_addr_q  <= 12'h000;
      last_unimp_q <= 1'b0;
      last_write_q <= 1'b0;
    end else begin
      cpu_ack_q <= cpu_req;                                     // see [RULE_04]
      if (cpu_req) begin
        cpu_rdata_q  <= src_byte;
        cpu_addr_q   <= cpu_write ? eff_dst : eff_src;
        last_addr_q  <= cpu_write ? eff_dst : eff_src;
        last_unimp_q <= unimp;
        last_write_q <= cpu_write;
      end
    end
  end

  // axi4-lite write path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q  <= 32'h0000_0000;
      w_lane0_q <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `RESP_OKAY;
      ext_q     <= `CFG_RST;
    end else begin
      if (aw_take) begin
        aw_got_q  <= 1'b1;
        awready_q <= 1'b0;
        aw_addr_q <= awaddr;
      end
      if (w_take) begin
        w_got_q   <= 1'b1;
        wready_q  <= 1'b0;
        w_data_q  <= wdata;
        w_lane0_q <= wstrb[0];
      end
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q  <= axi_hit ? `RESP_OKAY : `RESP_SLVERR;
        if (axi_cfg && w_lane0_q) begin
          ext_q <= w_data_q[`CFG_EXT_BIT];
        end
      end
      if (bvalid_q && bready) begin
        bvalid_q  <= 1'b0;
        aw_got_q  <= 1'b0;
        w_got_q   <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // axi4-lite read path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `RESP_OKAY;
    end else if (ar_take) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= ar_word;
      rresp_q   <= (ar_cfg || ar_stat || ar_bank) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign awready   = awready_q;
  assign wready    = wready_q;
  assign bvalid    = bvalid_q;
  assign bresp     = bresp_q;
  assign arready   = arready_q;
  assign rvalid    = rvalid_q;
  assign rdata     = rdata_q;
  assign rresp     = rresp_q;
  assign cpu_ack   = cpu_ack_q;
  assign cpu_rdata = cpu_rdata_q;
  assign cpu_addr  = cpu_addr_q;

  // checks
  wire short_rd = cpu_req && !cpu_we && !cpu_full_move;
  wire win_rd   = short_rd && !cpu_bank_sel && (cpu_offset != 8'hef) && (cpu_offset != 8'hf9)
                  && (cpu_offset != 8'hfa);

  sequence s_bank_wr;
    cpu_req && cpu_we && !cpu_full_move && cpu_bank_sel == 1'b0 && cpu_offset == 8'he0;
  endsequence
  sequence s_bank_rd;
    ar_take && araddr == `BANK_REG_OFF;
  endsequence

  one_cycle_ack_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see [RULE_04]
    cpu_req |=> cpu_ack_q ##1 (!cpu_ack_q || $past(cpu_req)))
    else $error("cpu access not answered in one cycle");
  bank_form_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see [RULE_02]
    short_rd && cpu_bank_sel && {bank_q, cpu_offset} != `INDIRECT_ADDR
    |=> cpu_addr_q == {$past(bank_q), $past(cpu_offset)})
    else $error("banked address not bank pointer joined to offset");
  window_low_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see [RULE_15]
    win_rd && !ext_q && cpu_offset < 8'h80 |=> cpu_addr_q == {4'h0, $past(cpu_offset)})
    else $error("low window offset not mapped into bank 0");
  window_high_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see [RULE_01]
    win_rd && cpu_offset >= 8'h80 |=> cpu_addr_q == {4'hf, $past(cpu_offset)})
    else $error("high window offset not mapped into bank 15");
  window_ignores_bank_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see [RULE_03]
    win_rd && !ext_q && cpu_offset < 8'h80 && bank_q != 4'h0 |=> cpu_addr_q[11:8] == 4'h0)
    else $error("fast window access used the bank pointer");
  ext_window_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see [RULE_05]
    win_rd && ext_q && cpu_offset < 8'h60 && (ptr_q + {4'h0, cpu_offset}) != `INDIRECT_ADDR
    |=> cpu_addr_q == $past(ptr_q) + {4'h0, $past(cpu_offset)})
    else $error("extended window not indexed from pointer");
  full_move_dst_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see [RULE_10]
    cpu_req && cpu_full_move && cpu_dst_addr != `INDIRECT_ADDR
    |=> cpu_addr_q == $past(cpu_dst_addr))
    else $error("full move destination not taken from encoding");
  unimp_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see [RULE_09]
    short_rd && unimp |=> cpu_rdata_q == 8'h00 && last_unimp_q)
    else $error("unimplemented location did not read zero");
  bank_upper_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see [RULE_13]
    s_bank_wr ##1 s_bank_rd |=> rvalid_q && rdata_q[31:4] == 28'h0 &&
    rdata_q[3:0] == $past(cpu_wdata[3:0], 2))
    else $error("bank pointer upper bits not zero or low bits not stored");
  indirect_redirect_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see [RULE_11]
    cpu_req && cpu_we && !cpu_full_move && !cpu_bank_sel && cpu_offset == 8'hef &&
    ptr_q != `INDIRECT_ADDR |=> cpu_addr_q == $past(ptr_q))
    else $error("indirect port access not redirected through pointer");
  write_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    aw_take && w_take |-> ##2 bvalid_q)
    else $error("write response not raised two cycles after both takes");
  read_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take |=> rvalid_q && !arready_q)
    else $error("read data not valid the cycle after address take");
endmodule : data_memory_bank_mapper

// ---- cpu_model.sv ----
// behavioural cpu execution side driving the data memory access port
`timescale 1ns/1ps
module cpu_model (
  // clock
  input  wire logic                   aclk,
  // access request
  output logic                        cpu_req,
  output logic                        cpu_we,
  output logic                        cpu_bank_sel,
  output logic                        cpu_full_move,
  output data_memory_pkg::byte_t      cpu_offset,
  output data_memory_pkg::addr_t      cpu_src_addr,
  output data_memory_pkg::addr_t      cpu_dst_addr,
  output data_memory_pkg::byte_t      cpu_wdata,
  // access answer
  input  wire data_memory_pkg::byte_t cpu_rdata,
  input  wire logic                   cpu_ack,
  input  wire data_memory_pkg::addr_t cpu_addr
);
  import data_memory_pkg::*;
  initial begin
    {cpu_req, cpu_we, cpu_bank_sel, cpu_full_move} = 4'h0;
    {cpu_offset, cpu_wdata} = 16'h0000;
    {cpu_src_addr, cpu_dst_addr} = 24'h000000;
  end
  // one request per call; the wait is bounded so a lost acknowledge cannot hang the run
  task automatic access(input logic we, input logic bs, input logic fm, input byte_t off,
                        input addr_t src, input addr_t dst, input byte_t wd,
                        output byte_t rd, output addr_t ea, output int lat);
    @(posedge aclk);
    cpu_req       <= 1'b1;
    cpu_we        <= we;
    cpu_bank_sel  <= bs;
    cpu_full_move <= fm;
    cpu_offset    <= off;
    cpu_src_addr  <= src;
    cpu_dst_addr  <= dst;
    cpu_wdata     <= wd;
    @(posedge aclk);
    cpu_req   <= 1'b0;
    // stale write data is inverted so nothing can lean on it after the take
    cpu_wdata <= ~wd;
    lat = 0;
    do begin
      @(posedge aclk);
      lat++;
    end while (cpu_ack !== 1'b1 && lat < 8);
    rd = cpu_rdata;
    ea = cpu_addr;
  endtask : access
endmodule : cpu_model

// ---- data_memory_bank_mapper_bench.sv ----
// self-checking bench of the data memory bank mapper
`timescale 1ns/1ps
`include "data_memory_defines.svh"
module data_memory_bank_mapper_bench;
  import data_memory_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, cpu_ack;
  logic cpu_req, cpu_we, cpu_bank_sel, cpu_full_move;
  addr_t awaddr, araddr, cpu_src_addr, cpu_dst_addr, cpu_addr, ea;
  word_t wdata, rdata, rw;
  logic [3:0] wstrb;
  resp_t bresp, rresp, rr;
  byte_t cpu_offset, cpu_wdata, cpu_rdata, rd;
  int    fail_count, cmp_count, cycles, lat;

  data_memory_bank_mapper i_data_memory_bank_mapper (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .cpu_req(cpu_req),
    .cpu_we(cpu_we), .cpu_bank_sel(cpu_bank_sel), .cpu_full_move(cpu_full_move),
    .cpu_offset(cpu_offset), .cpu_src_addr(cpu_src_addr), .cpu_dst_addr(cpu_dst_addr),
    .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_ack(cpu_ack), .cpu_addr(cpu_addr));
  cpu_model i_cpu_model (
    .aclk(aclk), .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_bank_sel(cpu_bank_sel),
    .cpu_full_move(cpu_full_move), .cpu_offset(cpu_offset), .cpu_src_addr(cpu_src_addr),
    .cpu_dst_addr(cpu_dst_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .cpu_ack(cpu_ack), .cpu_addr(cpu_addr));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // ceiling well above the fewer than two hundred cycles the sequence needs
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fail_count++;
      summarize();
    end
  end

  task summarize();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task chk_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  task chk_resp(input resp_t got, input resp_t exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_resp
  task do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset
  task axi_write(input addr_t a, input word_t d, output resp_t r);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {a, d, 4'h1};
    {awvalid, wvalid, bready} <= 3'b111;
    do begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (wvalid && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end while (!(aw_done && w_done));
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_write
  task axi_read(input addr_t a, output word_t d, output resp_t r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_read
  task cpu(input logic we, input logic bs, input logic fm, input byte_t off,
           input addr_t src, input addr_t dst, input byte_t wd);
    i_cpu_model.access(we, bs, fm, off, src, dst, wd, rd, ea, lat);
    chk_val(32'(lat), 32'h1);
  endtask : cpu

  task t_reset_regs();
    axi_read(`CFG_REG_OFF, rw, rr);
    chk_resp(rr, `RESP_OKAY);
    chk_val(rw, 32'h0);
    axi_read(`BANK_REG_OFF, rw, rr);
    chk_val(rw, 32'h0);
    axi_read(12'h100, rw, rr);
    chk_resp(rr, `RESP_SLVERR);
    chk_val(rw, 32'h0);
    axi_write(12'h100, 32'h1, rr);
    chk_resp(rr, `RESP_SLVERR);
  endtask : t_reset_regs
  task t_bank_window();
    axi_write(`BANK_REG_OFF, 32'h0000_00f2, rr);
    chk_resp(rr, `RESP_OKAY);
    axi_read(`BANK_REG_OFF, rw, rr);
    chk_val(rw, 32'h2);
    cpu(1'b1, 1'b1, 1'b0, 8'h34, 12'h000, 12'h000, 8'ha5);
    chk_val(ea, 12'h234);
    cpu(1'b1, 1'b0, 1'b0, 8'h34, 12'h000, 12'h000, 8'h5a);
    chk_val(ea, 12'h034);
    cpu(1'b0, 1'b1, 1'b0, 8'h34, 12'h000, 12'h000, 8'h00);
    chk_val(rd, 8'ha5);
    cpu(1'b0, 1'b0, 1'b0, 8'h34, 12'h000, 12'h000, 8'h00);
    chk_val(rd, 8'h5a);
    // bus read of the bank pointer one edge after a cpu write to it
    fork
      cpu(1'b1, 1'b0, 1'b0, 8'he0, 12'h000, 12'h000, 8'hf7);
      begin
        @(posedge aclk);
        axi_read(`BANK_REG_OFF, rw, rr);
      end
    join
    chk_val(ea, 12'hfe0);
    chk_val(rw, 32'h7);
  endtask : t_bank_window
  task t_special_area();
    cpu(1'b1, 1'b0, 1'b0, 8'h80, 12'h000, 12'h000, 8'h3c);
    chk_val(ea, 12'hf80);
    cpu(1'b0, 1'b0, 1'b0, 8'h80, 12'h000, 12'h000, 8'h00);
    chk_val(rd, 8'h3c);
    cpu(1'b1, 1'b0, 1'b0, 8'ha0, 12'h000, 12'h000, 8'hff);
    cpu(1'b0, 1'b0, 1'b0, 8'ha0, 12'h000, 12'h000, 8'h00);
    chk_val({ea, rd}, 20'hfa0_00);
    axi_read(`STAT_REG_OFF, rw, rr);
    chk_val(rw, 32'h0001_0fa0);
  endtask : t_special_area
  task t_unimpl_bank();
    axi_write(`BANK_REG_OFF, 32'h5, rr);
    cpu(1'b1, 1'b1, 1'b0, 8'h10, 12'h000, 12'h000, 8'h77);
    chk_val(ea, 12'h510);
    cpu(1'b0, 1'b1, 1'b0, 8'h10, 12'h000, 12'h000, 8'h00);
    chk_val(rd, 8'h00);
  endtask : t_unimpl_bank
  task t_ram_base();
    cpu(1'b1, 1'b0, 1'b0, 8'h00, 12'h000, 12'h000, 8'h11);
    chk_val(ea, 12'h000);
    cpu(1'b0, 1'b0, 1'b0, 8'h00, 12'h000, 12'h000, 8'h00);
    chk_val(rd, 8'h11);
  endtask : t_ram_base
  task t_indirect_move();
    cpu(1'b1, 1'b0, 1'b0, 8'he9, 12'h000, 12'h000, 8'h10);
    cpu(1'b1, 1'b0, 1'b0, 8'hea, 12'h000, 12'h000, 8'h01);
    cpu(1'b1, 1'b0, 1'b0, 8'hef, 12'h000, 12'h000, 8'h66);
    chk_val(ea, 12'h110);
    axi_read(`STAT_REG_OFF, rw, rr);
    chk_val(rw, 32'h0002_0110);
    // source lies outside both windows, so the move reaches it by its full address
    cpu(1'b0, 1'b0, 1'b1, 8'h00, 12'h110, 12'h00f, 8'h00);
    chk_val({ea, rd}, 20'h00f_66);
    cpu(1'b0, 1'b0, 1'b0, 8'h0f, 12'h000, 12'h000, 8'h00);
    chk_val(rd, 8'h66);
  endtask : t_indirect_move
  task t_extended();
    axi_write(`CFG_REG_OFF, 32'h1, rr);
    axi_read(`CFG_REG_OFF, rw, rr);
    chk_val(rw, 32'h1);
    cpu(1'b0, 1'b0, 1'b0, 8'h05, 12'h000, 12'h000, 8'h00);
    chk_val(ea, 12'h115);
    cpu(1'b0, 1'b0, 1'b0, 8'h70, 12'h000, 12'h000, 8'h00);
    chk_val(ea, 12'h070);
    axi_write(`CFG_REG_OFF, 32'h0, rr);
  endtask : t_extended
  task t_keep_ram();
    do_reset();
    cpu(1'b0, 1'b0, 1'b0, 8'h34, 12'h000, 12'h000, 8'h00);
    chk_val(rd, 8'h5a);
    cpu(1'b0, 1'b0, 1'b0, 8'h00, 12'h000, 12'h000, 8'h00);
    chk_val(rd, 8'h11);
  endtask : t_keep_ram

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = 60'h0;
    {fail_count, cmp_count, cycles} = {32'h0, 32'h0, 32'h0};
    do_reset();
    t_reset_regs();
    t_bank_window();
    t_special_area();
    t_unimpl_bank();
    t_ram_base();
    t_indirect_move();
    t_extended();
    t_keep_ram();
    summarize();
  end
endmodule : data_memory_bank_mapper_bench
